//--- include/bsm_defines.vh
`ifndef BSM_DEFINES_VH
`define BSM_DEFINES_VH
// Register offset of the power control and status register
`define BSM_REG_PWR_CTRL 8'h02
// Field positions inside the power control and status register
`define BSM_PM_HI 7
`define BSM_PM_LO 5
`define BSM_SSF_BIT 3
`define BSM_BLF_BIT 2
`define BSM_SSIE_BIT 1
`define BSM_BATTERY_LOW_IRQ_EN_BIT 0
// Reset values
`define BSM_PM_RESET 3'h7
`define BSM_REG_RESET 8'he0
// Comparator levels during reset: main taken as absent, battery healthy
`define BSM_CMP_RESET 3'h3
// Power mode codes
`define BSM_PM_STD_LB 3'h0
`define BSM_PM_DIR_LB 3'h1
`define BSM_PM_OFF_A 3'h2
`define BSM_PM_OFF_B 3'h3
`define BSM_PM_STD 3'h4
`define BSM_PM_DIR 3'h5
`define BSM_PM_BAD 3'h6
`define BSM_PM_OFF 3'h7
// Supply states
`define BSM_ST_STANDBY 2'h0
`define BSM_ST_MAIN 2'h1
`define BSM_ST_BATTERY 2'h2
`endif

//--- core/bsm_sync2.v
`timescale 1ns/100ps
`include "bsm_defines.vh"
// Two flip-flop level synchroniser for a bundle of comparator levels
module bsm_sync2 (
  input wire clk_i,          // System clock
  input wire rstn_i,         // Active low reset
  input wire [2:0] async_i,  // Raw comparator levels
  output reg [2:0] sync_o    // Synchronised levels
);

  reg [2:0] meta; // First stage, read only by second stage

  // Two stage capture against metastability
  // Reset reads as main absent, so the state machine cannot see a false
  // main supply before the first real levels have passed both stages
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= `BSM_CMP_RESET;
      sync_o <= `BSM_CMP_RESET;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

//--- core/bsm_backup_supply_manager.v
`timescale 1ns/100ps
`include "bsm_defines.vh"

////////////////////////////////////////////////////////////////////////////
module bsm_backup_supply_manager (
  input wire clk_sys_i,        // 10 MHz system clock
  input wire rstn_i,           // Active low power-on reset
  input wire main_below_bat_i, // Main supply is below battery
  input wire main_below_thr_i, // Main supply below switch_threshold
  input wire bat_low_i,        // Battery below low_battery_threshold
  input wire reg_wr_i,         // Host register write strobe
  input wire reg_rd_i,         // Host register read strobe
  input wire [7:0] reg_addr_i, // Host register address
  input wire [7:0] reg_wdata_i, // Host write data
  input wire clock_output_pin_en_i,      // Clock output enabled on shared pin
  input wire clock_output_pin_i,         // Clock to place on shared pin
  output reg [7:0] reg_rdata_o, // Host read data
  output wire rdata_oe_o,      // Host read data drive enable
  output wire irq_out_primary_o, // Shared pin output level
  output wire irq_out_primary_oe_o, // Shared pin drive enable
  output wire on_battery_o,    // Internal supply is the battery
  output wire standby_o,       // Standby, nothing drawn from battery
  output wire [1:0] supply_state_o // Current supply state
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  reg [1:0] rst_pipe; // Reset release shift
  wire rst_n;         // Synchronised reset used everywhere

  // Asynchronous assert, clocked release
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  ////////////////////////////////////////////////////////////////////////
  // Comparator synchronisation
  wire [2:0] cmp_sync; // Synchronised comparator levels
  wire below_bat;      // Main below battery
  wire below_thr;      // Main below switch threshold
  wire low_bat;        // Battery low

  bsm_sync2 u_sync (
    .clk_i(clk_sys_i),
    .rstn_i(rst_n),
    .async_i({bat_low_i, main_below_thr_i, main_below_bat_i}),
    .sync_o(cmp_sync)
  );
  assign below_bat = cmp_sync[0];
  assign below_thr = cmp_sync[1];
  assign low_bat = cmp_sync[2];

  ////////////////////////////////////////////////////////////////////////
  // Power mode decode
  reg [2:0] power_mode_select;    // Power mode field
  reg supply_switch_flag;         // Set on switch to battery
  reg battery_low_flag;           // Set while battery low
  reg supply_switch_irq_en;       // Switch flag interrupt enable
  reg battery_low_irq_en;         // Low flag interrupt enable
  reg [1:0] state;                // Supply state
  reg [1:0] next_state;           // Next supply state

  // Switch-over enabled for modes 000, 001, 100, 101
  function sw_enabled;
    input [2:0] pm;
    begin
      case (pm)
        `BSM_PM_STD_LB, `BSM_PM_DIR_LB, `BSM_PM_STD, `BSM_PM_DIR:
          sw_enabled = 1'b1;
        default:
          sw_enabled = 1'b0;
      endcase
    end
  endfunction

  wire sw_en;     // Switch-over active
  wire direct;    // Direct switching mode
  wire lowdet_en; // Battery low detection active
  wire pm_fail;   // Power failure condition

  assign sw_en = sw_enabled(power_mode_select);
  assign direct = power_mode_select[0];
  assign lowdet_en = ~power_mode_select[2];
  // Direct mode uses battery comparison only
  assign pm_fail = direct ? below_bat : (below_bat & below_thr);

  ////////////////////////////////////////////////////////////////////////
  // Supply state machine
  // Main is taken present when not below battery; from battery, when not in a failure condition
  always @* begin
    next_state = state;
    case (state)
      `BSM_ST_STANDBY: begin
        if (!below_bat)
          next_state = `BSM_ST_MAIN;
      end
      `BSM_ST_MAIN: begin
        if (below_bat) begin
          if (!sw_en)
            next_state = `BSM_ST_STANDBY;
          else if (pm_fail)
            next_state = `BSM_ST_BATTERY;
        end
      end
      `BSM_ST_BATTERY: begin
        if (!pm_fail)
          next_state = `BSM_ST_MAIN;
      end
      default:
        next_state = `BSM_ST_STANDBY;
    endcase
  end

  // State register, reset lands in standby since supply is unknown
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n)
      state <= `BSM_ST_STANDBY;
    else
      state <= next_state;
  end

  wire on_bat;     // Running from battery
  wire enter_bat;  // One-cycle entry to battery
  wire host_ok;    // Host interface live
  wire wr_hit;     // Accepted write to the register
  assign on_bat = (state == `BSM_ST_BATTERY);
  assign enter_bat = (next_state == `BSM_ST_BATTERY) & ~on_bat;
  assign host_ok = (state == `BSM_ST_MAIN);
  assign wr_hit = host_ok & reg_wr_i & (reg_addr_i == `BSM_REG_PWR_CTRL);

  ////////////////////////////////////////////////////////////////////////
  // Register and flags
  // Writable fields; low flag is never taken from host data
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      power_mode_select <= `BSM_PM_RESET;
      supply_switch_irq_en <= 1'b0;
      battery_low_irq_en <= 1'b0;
      supply_switch_flag <= 1'b0;
      battery_low_flag <= 1'b0;
    end else begin
      if (wr_hit) begin
        power_mode_select <= reg_wdata_i[`BSM_PM_HI:`BSM_PM_LO];
        supply_switch_irq_en <= reg_wdata_i[`BSM_SSIE_BIT];
        battery_low_irq_en <= reg_wdata_i[`BSM_BATTERY_LOW_IRQ_EN_BIT];
      end
      if (!sw_en)
        supply_switch_flag <= 1'b0;
      // Set on battery entry, set beats clear
      else if (enter_bat)
        supply_switch_flag <= 1'b1;
      else if (wr_hit && !reg_wdata_i[`BSM_SSF_BIT])
        supply_switch_flag <= 1'b0;
      // Set while low, also on battery
      if (lowdet_en)
        battery_low_flag <= low_bat;
      else
        battery_low_flag <= 1'b0;
    end
  end

  // Read data register; bit 4 reads zero
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n)
      reg_rdata_o <= `BSM_REG_RESET;
    else if (host_ok && reg_rd_i && reg_addr_i == `BSM_REG_PWR_CTRL)
      reg_rdata_o <= {power_mode_select, 1'b0, supply_switch_flag,
                      battery_low_flag, supply_switch_irq_en,
                      battery_low_irq_en};
  end
  assign rdata_oe_o = host_ok & reg_rd_i;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt pin
  wire irq_any; // Any enabled source active
  // Low flag gated by its enable
  assign irq_any = (supply_switch_flag & supply_switch_irq_en) |
                   (battery_low_flag & battery_low_irq_en);
  // Open drain low; clock output takes priority
  assign irq_out_primary_o = clock_output_pin_en_i ? clock_output_pin_i : 1'b0;
  assign irq_out_primary_oe_o = clock_output_pin_en_i ? 1'b1 : irq_any;

  assign on_battery_o = on_bat;
  assign standby_o = (state == `BSM_ST_STANDBY);
  assign supply_state_o = state;

endmodule

//--- verification/bsm_supply_model.sv
`timescale 1ns/100ps
// Ideal supply comparators on millivolt figures
module bsm_supply_model #(
  parameter int SW_MV = 2500,  // Plain default switch level
  parameter int LOW_MV = 2500  // Plain default low level
) (
  input int vdd_i,             // Main supply
  input int vbat_i,            // Battery
  output logic below_bat_o,    // Main under battery
  output logic below_thr_o,    // Main under switch level
  output logic bat_low_o       // Battery under low level
);
  // No hysteresis, so the bench steps levels well clear of them
  assign below_bat_o = vdd_i < vbat_i;
  assign below_thr_o = vdd_i < SW_MV;
  assign bat_low_o = vbat_i < LOW_MV;
endmodule

//--- verification/bsm_backup_supply_manager_asserts.sv
`timescale 1ns/100ps
// Pin level checks of the supply manager
module bsm_checker (
  input wire clk_sys_i, rstn_i, main_below_bat_i, main_below_thr_i,
  input wire bat_low_i, reg_wr_i, reg_rd_i, clock_output_pin_en_i, clock_output_pin_i,
  input wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
  input wire rdata_oe_o, irq_out_primary_o, irq_out_primary_oe_o,
  input wire on_battery_o, standby_o,
  input wire [1:0] supply_state_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  rd_drive_a: assert property (rdata_oe_o ==
    (reg_rd_i && supply_state_o == 2'h1)) else $error("read drive");
  rd_hold_a: assert property (on_battery_o && $past(on_battery_o)
    |-> $stable(reg_rdata_o)) else $error("rdata moved");
  stby_bat_a: assert property (supply_state_o == 2'h0
    |=> supply_state_o != 2'h2) else $error("standby to battery");
  main_loss_a: assert property (supply_state_o == 2'h1 ##1
    supply_state_o != 2'h1 |-> $past(main_below_bat_i, 3))
    else $error("left main early");
  main_back_a: assert property (supply_state_o == 2'h0 ##1
    supply_state_o == 2'h1 |-> !$past(main_below_bat_i, 3))
    else $error("left standby early");
  irq_low_a: assert property (irq_out_primary_oe_o && !clock_output_pin_en_i
    |-> !irq_out_primary_o) else $error("irq level");
  bat_flag_a: assert property (on_battery_o ==
    (supply_state_o == 2'h2)) else $error("battery flag");
  stby_flag_a: assert property (standby_o ==
    (supply_state_o == 2'h0)) else $error("standby flag");
  clk_pin_a: assert property (clock_output_pin_en_i |-> irq_out_primary_oe_o
    && irq_out_primary_o == clock_output_pin_i) else $error("clock pin");
  bat_c: cover property ($rose(on_battery_o));
  stby_c: cover property (supply_state_o == 2'h1 ##1 standby_o);
  irq_c: cover property ($rose(irq_out_primary_oe_o));
  clk_c: cover property (clock_output_pin_en_i && irq_out_primary_o);
endmodule

//--- verification/tb_backup_supply_manager.sv
`timescale 1ns/100ps
module tb_backup_supply_manager;
  logic clk_sys_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic clock_output_pin_en_i = 0, clock_output_pin_i = 0;
  logic [7:0] reg_addr_i = 8'h02, reg_wdata_i = 8'h00, reg_rdata_o;
  logic rdata_oe_o, irq_out_primary_o, irq_out_primary_oe_o;
  logic on_battery_o, standby_o, main_below_bat_i, main_below_thr_i;
  logic bat_low_i;
  logic [1:0] supply_state_o;
  int vdd = 0, vbat = 3000, miscompares = 0, checked = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  bsm_backup_supply_manager dut (.*);
  bsm_supply_model sup (.vdd_i(vdd), .vbat_i(vbat),
    .below_bat_o(main_below_bat_i), .below_thr_o(main_below_thr_i),
    .bat_low_o(bat_low_i));
  task results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input [7:0] s, input [7:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // One-cycle strobes, driven off the sampling edge
  task wr(input [7:0] a, input [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    cyc(1);
    reg_wr_i = 0;
    cyc(1);
  endtask
  // Read strobe; drive enable judged while the strobe still stands
  task rd(input [7:0] a, input [7:0] e, input o);
    reg_addr_i = a;
    reg_rd_i = 1;
    cyc(1);
    chk(rdata_oe_o, o);
    reg_rd_i = 0;
    cyc(1);
    chk(reg_rdata_o, e);
  endtask
  // Bounded wait on the supply state
  task wst(input [1:0] e);
    int i;
    for (i = 0; i < 20 && supply_state_o !== e; i++) cyc(1);
    chk(supply_state_o, e);
    chk(standby_o, e == 2'h0);
    chk(on_battery_o, e == 2'h2);
    if (supply_state_o !== e) results();
  endtask
  task t_modes;
    int m;
    for (m = 0; m < 8; m++) begin
      wr(8'h02, {m[2:0], 5'h00});
      rd(8'h02, {m[2:0], 5'h00}, 1);
    end
    wr(8'h03, 8'h1f);
    rd(8'h03, 8'he0, 1);
    rd(8'h02, 8'he0, 1);
    $display("modes done");
  endtask
  task t_dir;
    wr(8'h02, 8'ha2);
    vdd = 2900;
    wst(2'h2);
    chk(irq_out_primary_oe_o, 1);
    wr(8'h02, 8'h00);
    rd(8'h02, 8'he0, 0);
    vdd = 3300;
    wst(2'h1);
    chk(irq_out_primary_oe_o, 1);
    rd(8'h02, 8'haa, 1);
    // Host clears the switch flag only once main is back
    wr(8'h02, 8'ha2);
    rd(8'h02, 8'ha2, 1);
    chk(irq_out_primary_oe_o, 0);
    $display("direct done");
  endtask
  task t_std;
    wr(8'h02, 8'h80);
    vdd = 2900;
    cyc(8);
    chk(supply_state_o, 2'h1);
    vdd = 2000;
    wst(2'h2);
    vdd = 3300;
    wst(2'h1);
    chk(irq_out_primary_oe_o, 0);
    rd(8'h02, 8'h88, 1);
    wr(8'h02, 8'h80);
    rd(8'h02, 8'h80, 1);
    $display("standard done");
  endtask
  task t_off;
    // Leave the switch flag set, then turn switch-over off
    wr(8'h02, 8'ha2);
    vdd = 2900;
    wst(2'h2);
    vdd = 3300;
    wst(2'h1);
    wr(8'h02, 8'hea);
    rd(8'h02, 8'he2, 1);
    chk(irq_out_primary_oe_o, 0);
    // Mode 010 also runs from main only
    wr(8'h02, 8'h42);
    vdd = 2000;
    wst(2'h0);
    vdd = 3300;
    wst(2'h1);
    // Mode 111 written before main is removed
    wr(8'h02, 8'he2);
    vdd = 2000;
    wst(2'h0);
    vdd = 3300;
    wst(2'h1);
    rd(8'h02, 8'he2, 1);
    chk(irq_out_primary_oe_o, 0);
    $display("off done");
  endtask
  task t_low;
    wr(8'h02, 8'h01);
    vbat = 2000;
    cyc(6);
    chk(irq_out_primary_oe_o, 1);
    chk(irq_out_primary_o, 0);
    wr(8'h02, 8'h01);
    rd(8'h02, 8'h05, 1);
    // A healthy battery drops the flag and the pin
    vbat = 3000;
    cyc(6);
    chk(irq_out_primary_oe_o, 0);
    wr(8'h02, 8'h05);
    rd(8'h02, 8'h01, 1);
    // Clearing the enable releases the pin while the flag stays
    vbat = 2000;
    cyc(6);
    wr(8'h02, 8'h00);
    chk(irq_out_primary_oe_o, 0);
    rd(8'h02, 8'h04, 1);
    vbat = 3000;
    cyc(6);
    // Detection keeps running on battery
    wr(8'h02, 8'h21);
    vdd = 1000;
    vbat = 2000;
    wst(2'h2);
    cyc(4);
    chk(irq_out_primary_oe_o, 1);
    vdd = 3300;
    wst(2'h1);
    rd(8'h02, 8'h2d, 1);
    vbat = 3000;
    cyc(6);
    wr(8'h02, 8'h20);
    rd(8'h02, 8'h20, 1);
    // Clock output owns the shared pin
    clock_output_pin_en_i = 1;
    clock_output_pin_i = 1;
    cyc(1);
    chk(irq_out_primary_oe_o, 1);
    chk(irq_out_primary_o, 1);
    clock_output_pin_i = 0;
    cyc(1);
    chk(irq_out_primary_o, 0);
    clock_output_pin_en_i = 0;
    cyc(1);
    chk(irq_out_primary_oe_o, 0);
    $display("low done");
  endtask
  initial begin
    cyc(5);
    rstn_i = 1;
    cyc(10);
    wst(2'h0);
    vdd = 3300;
    wst(2'h1);
    rd(8'h02, 8'he0, 1);
    t_modes;
    t_dir;
    t_std;
    t_off;
    t_low;
    results;
  end
endmodule
bind bsm_backup_supply_manager bsm_checker chk_i (.*);
